// ---- rtl/alarm_pkg.sv ----
// Purpose: Shared constants and types of the servo alarm manager
// Assumes: 100 MHz clock
// Notes:   Alarm index 0 is the highest priority
package alarm_pkg;

  localparam int unsigned ALARM_COUNT       = 15;
  localparam int unsigned CLK_HZ            = 100000000;
  localparam int unsigned BLINK_MS          = 500;
  localparam int unsigned BLINK_CYCLES      = (CLK_HZ / 1000) * BLINK_MS;
  localparam int unsigned BLINK_CNT_WIDTH   = 26;
  localparam int unsigned TERMINAL_COUNT    = 5;
  localparam int unsigned FUNC_WIDTH        = 5;
  localparam logic [4:0]  FUNC_NONE         = 5'h00;
  localparam logic [4:0]  FUNC_FORCED_STOP  = 5'h05;
  localparam logic [15:0] DC_LINK_LIMIT_V   = 16'h01a4;   // 420 V
  localparam int unsigned OVERSPEED_NUM     = 11;         // 1.1 = 11/10
  localparam int unsigned OVERSPEED_DEN     = 10;
  localparam logic [14:0] ALARM_RESET_VALUE = 15'h0000;
  localparam logic [7:0]  DISPLAY_SEL_RESET = 8'h00;

  // Alarm bit positions, in priority order
  localparam int unsigned AL_OC1 = 0;
  localparam int unsigned AL_OC2 = 1;
  localparam int unsigned AL_OS  = 2;
  localparam int unsigned AL_OV  = 3;
  localparam int unsigned AL_ENC = 4;
  localparam int unsigned AL_CTL = 5;
  localparam int unsigned AL_MEM = 6;
  localparam int unsigned AL_RTR = 7;
  localparam int unsigned AL_ECM = 8;
  localparam int unsigned AL_DUP = 9;
  localparam int unsigned AL_OL  = 10;
  localparam int unsigned AL_LV  = 11;
  localparam int unsigned AL_RRS = 12;
  localparam int unsigned AL_DEV = 13;
  localparam int unsigned AL_AMP = 14;

  // Alarms that survive a sequence or keypad reset
  localparam logic [14:0] FATAL_MASK = 15'h0270;
  // Alarms that coast at once; the rest decelerate first
  localparam logic [14:0] COAST_MASK = 15'h03ff;

  typedef enum logic [1:0] {MODE_POSITION, MODE_SPEED, MODE_TORQUE} control_mode_type;

  typedef enum logic [3:0] {
    SEQ_BASE_OFF, SEQ_SERVO_ON, SEQ_READY_PULSE, SEQ_READY_TEST,
    SEQ_STOP_POS_OT, SEQ_STOP_NEG_OT, SEQ_STOP_FORCED, SEQ_UNDERVOLT
  } seq_state_type;

  typedef enum logic [1:0] {STOP_NONE, STOP_COAST, STOP_DECEL, STOP_DECEL_COAST} stop_type;

  // Raw detector inputs
  typedef struct packed {
    logic        overcurrent1;
    logic        overcurrent2;
    logic [15:0] speed;
    logic [15:0] max_speed;
    logic [15:0] dc_link_v;
    logic        encoder_fault;
    logic        control_power_fault;
    logic        memory_fault;
    logic        regen_transistor_hot;
    logic        encoder_comm_fault;
    logic        overload;
    logic        undervoltage;
    logic        regen_resistor_hot;
    logic        deviation_limit;
    logic        amplifier_hot;
  } detect_type;

  // Display word: symbolic codes, decoded to segments elsewhere
  typedef struct packed {
    logic             alarm_shown;
    logic             blank;
    logic [3:0]       alarm_code;
    control_mode_type mode;
    seq_state_type    seq;
    logic [7:0]       select;
  } display_type;

endpackage : alarm_pkg

// ---- rtl/servo_alarm_manager.sv ----
// Purpose: Alarm latching, priority display, stop action and reset of a servo amplifier
// Assumes: Detector inputs are asynchronous to clk; terminal assignments are static
// Notes:   Faults latch five edges after they appear, through a four-stage pin path;
//          fatal classes clear only on rstn, which stands for a power cycle
// Contract
// RULE1 - Without alarms, show the quantity chosen by the display selection setting
// RULE2 - Without alarms, first digit shows position, speed or torque control mode
// RULE3 - Digits two to four show base off, servo on, pulse ready, test ready
// RULE4 - Also distinct codes for both overtravels, forced stop and undervoltage
// RULE5 - Any detected alarm replaces the normal display with its blinking code
// RULE6 - Several alarms pending: show the highest priority of fifteen fixed ranks
// RULE7 - Alarm display blinks with a half second toggle interval
// RULE8 - Ten alarm classes drop drive at once and let the motor coast
// RULE9 - Five alarm classes decelerate at maximum torque, then coast
// RULE10 - Reset sequence input clears pending resettable alarms
// RULE11 - Encoder, control power, memory, duplication alarms only clear by power cycle
// RULE12 - Keypad test mode alarm reset also clears resettable alarms
// RULE13 - Main transistor overcurrent raises an overcurrent alarm
// RULE14 - Speed above 1.1 times rated maximum raises overspeed
// RULE15 - DC link above its limit raises overvoltage
// RULE16 - Parameter set can be read out to and written from a loader
// RULE17 - Overvoltage threshold is about 420 volts
// RULE18 - Same function on two terminals raises duplication, forced stop excepted
// RULE19 - Alarm flags stay latched until a valid reset or power cycle
`timescale 1ns/1ps
module servo_alarm_manager
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // Detectors and status
  input  wire alarm_pkg::detect_type       detect,
  input  wire alarm_pkg::control_mode_type mode_in,
  input  wire alarm_pkg::seq_state_type    seq_in,
  input  wire logic [7:0]                  display_select,
  input  wire logic [24:0]                 sequence_input_terminal_func,
  // Reset requests
  input  wire logic                        seq_reset,
  input  wire logic                        keypad_alarm_reset,
  // Parameter loader
  input  wire logic                        param_wr,
  input  wire logic [6:0]                  param_addr,
  input  wire logic [15:0]                 param_wdata,
  output logic [15:0]                      param_rdata,
  // Results
  output alarm_pkg::display_type           display,
  output logic                             display_on,
  output alarm_pkg::stop_type              stop_action,
  output logic [14:0]                      alarm_flags
);

  localparam int unsigned BLINK_CNT_WIDTH_L = alarm_pkg::BLINK_CNT_WIDTH;

  alarm_pkg::detect_type        detect_s1;
  alarm_pkg::detect_type        detect_s2;
  alarm_pkg::detect_type        detect_s3;
  alarm_pkg::detect_type        settled;
  logic [19:0]                  speed_scaled;
  logic [19:0]                  limit_scaled;
  logic [3:0]                   dup_line;
  logic [14:0]                  raw;
  logic                         rst_s1;
  logic                         rst_s2;
  logic                         rst_s3;
  logic                         key_s1;
  logic                         key_s2;
  logic                         key_s3;
  logic [14:0]                  next_alarm;
  logic                         clear;
  logic [BLINK_CNT_WIDTH_L-1:0] blink_cnt;
  logic                         blink;
  logic [3:0]                   top_code;
  logic                         dup;
  logic [15:0]                  param_mem [0:127];

  // Duplicate terminal assignment check; forced stop may repeat
  always_comb
  begin
    dup = 1'b0;
    for (int i = 0; i < alarm_pkg::TERMINAL_COUNT; i++)
      for (int j = i + 1; j < alarm_pkg::TERMINAL_COUNT; j++)
        if (sequence_input_terminal_func[i*5 +: 5] == sequence_input_terminal_func[j*5 +: 5] &&
            sequence_input_terminal_func[i*5 +: 5] != alarm_pkg::FUNC_NONE &&
            sequence_input_terminal_func[i*5 +: 5] != alarm_pkg::FUNC_FORCED_STOP)
          dup = 1'b1; // RULE18
  end

  // Two-stage synchronisers; no logic reads a detector before the second stage
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      detect_s1 <= '0;
      detect_s2 <= '0;
    end
    else
    begin
      detect_s1 <= detect;
      detect_s2 <= detect_s1;
    end
  end

  // Third stage. A word is taken only when two samples agree, so a word caught
  // mid-change never reaches a comparator; a word that changes every clock is never taken
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      detect_s3 <= '0;
      settled   <= '0;
    end
    else
    begin
      detect_s3 <= detect_s2;
      // Single-bit faults only step on, keeping the same depth as the words
      settled.overcurrent1         <= detect_s3.overcurrent1;
      settled.overcurrent2         <= detect_s3.overcurrent2;
      settled.encoder_fault        <= detect_s3.encoder_fault;
      settled.control_power_fault  <= detect_s3.control_power_fault;
      settled.memory_fault         <= detect_s3.memory_fault;
      settled.regen_transistor_hot <= detect_s3.regen_transistor_hot;
      settled.encoder_comm_fault   <= detect_s3.encoder_comm_fault;
      settled.overload             <= detect_s3.overload;
      settled.undervoltage         <= detect_s3.undervoltage;
      settled.regen_resistor_hot   <= detect_s3.regen_resistor_hot;
      settled.deviation_limit      <= detect_s3.deviation_limit;
      settled.amplifier_hot        <= detect_s3.amplifier_hot;
      // Words hold their last agreed value
      if (detect_s2.speed == detect_s3.speed)
        settled.speed <= detect_s2.speed;
      if (detect_s2.max_speed == detect_s3.max_speed)
        settled.max_speed <= detect_s2.max_speed;
      if (detect_s2.dc_link_v == detect_s3.dc_link_v)
        settled.dc_link_v <= detect_s2.dc_link_v;
    end
  end

  // Duplication check delayed to the detector depth, so that faults raised
  // together latch on one edge and the shown code does not step through them
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      dup_line <= 4'h0;
    else
      dup_line <= {dup_line[2:0], dup}; // RULE18
  end

  // Overspeed compares speed*10 with max*11; 20 bits hold both products without loss
  always_comb
  begin
    speed_scaled = {4'h0, settled.speed} * 20'(alarm_pkg::OVERSPEED_DEN);
    limit_scaled = {4'h0, settled.max_speed} * 20'(alarm_pkg::OVERSPEED_NUM);
  end

  // Raw fault conditions, taken from settled samples except duplication, which comes from dup_line
  always_comb
  begin
    raw = 15'h0000;
    raw[alarm_pkg::AL_OC1] = settled.overcurrent1; // RULE13
    raw[alarm_pkg::AL_OC2] = settled.overcurrent2; // RULE13
    raw[alarm_pkg::AL_OS]  = speed_scaled > limit_scaled; // RULE14
    raw[alarm_pkg::AL_OV]  = settled.dc_link_v > alarm_pkg::DC_LINK_LIMIT_V; // RULE15 RULE17
    raw[alarm_pkg::AL_ENC] = settled.encoder_fault;
    raw[alarm_pkg::AL_CTL] = settled.control_power_fault;
    raw[alarm_pkg::AL_MEM] = settled.memory_fault;
    raw[alarm_pkg::AL_RTR] = settled.regen_transistor_hot;
    raw[alarm_pkg::AL_ECM] = settled.encoder_comm_fault;
    raw[alarm_pkg::AL_DUP] = dup_line[3];
    raw[alarm_pkg::AL_OL]  = settled.overload;
    raw[alarm_pkg::AL_LV]  = settled.undervoltage;
    raw[alarm_pkg::AL_RRS] = settled.regen_resistor_hot;
    raw[alarm_pkg::AL_DEV] = settled.deviation_limit;
    raw[alarm_pkg::AL_AMP] = settled.amplifier_hot;
  end

  // Sequence reset pin; the third stage gives a rising-edge detect
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
      rst_s3 <= 1'b0;
    end
    else
    begin
      rst_s1 <= seq_reset;
      rst_s2 <= rst_s1;
      rst_s3 <= rst_s2;
    end
  end

  // Keypad alarm reset; edge detected too, so a held key clears only once
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      key_s1 <= 1'b0;
      key_s2 <= 1'b0;
      key_s3 <= 1'b0;
    end
    else
    begin
      key_s1 <= keypad_alarm_reset;
      key_s2 <= key_s1;
      key_s3 <= key_s2;
    end
  end

  assign clear = (rst_s2 & ~rst_s3) | (key_s2 & ~key_s3); // RULE10 RULE12

  // Latch: a fault present in the clear cycle still sets its flag
  always_comb
  begin
    next_alarm = alarm_flags;
    if (clear)
      next_alarm = alarm_flags & alarm_pkg::FATAL_MASK; // RULE11
    next_alarm = next_alarm | raw; // RULE19
  end

  // Alarm flags; only rstn (power on) clears the fatal classes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      alarm_flags <= alarm_pkg::ALARM_RESET_VALUE;
    else
      alarm_flags <= next_alarm; // RULE19
  end

  // Priority encoder, lowest index wins
  always_comb
  begin
    top_code = 4'hf;
    for (int k = alarm_pkg::ALARM_COUNT - 1; k >= 0; k--)
      if (alarm_flags[k])
        top_code = 4'(k); // RULE6
  end

  // Half-second blink toggle; free-running so phase is not tied to the alarm
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      blink_cnt <= '0;
      blink     <= 1'b1;
    end
    else if (blink_cnt == BLINK_CNT_WIDTH_L'(alarm_pkg::BLINK_CYCLES - 1))
    begin
      blink_cnt <= '0;
      blink     <= ~blink; // RULE7
    end
    else
      blink_cnt <= blink_cnt + 1'b1;
  end

  // Display word
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      display    <= '0;
      display_on <= 1'b0;
    end
    else
    begin
      display_on           <= 1'b1;
      display.select       <= display_select; // RULE1
      display.mode         <= mode_in; // RULE2
      display.seq          <= seq_in; // RULE3 RULE4
      display.alarm_shown  <= |alarm_flags; // RULE5
      display.alarm_code   <= top_code; // RULE6
      display.blank        <= (|alarm_flags) & ~blink; // RULE5 RULE7
    end
  end

  // Stop action chosen from the highest priority class present
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      stop_action <= alarm_pkg::STOP_NONE;
    else if (|(alarm_flags & alarm_pkg::COAST_MASK))
      stop_action <= alarm_pkg::STOP_COAST; // RULE8
    else if (|alarm_flags)
      stop_action <= alarm_pkg::STOP_DECEL_COAST; // RULE9
    else
      stop_action <= alarm_pkg::STOP_NONE;
  end

  // Parameter store for loader copy in both directions
  always_ff @(posedge clk)
  begin
    if (param_wr)
      param_mem[param_addr] <= param_wdata; // RULE16
  end

  // Registered read port for loader upload
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      param_rdata <= 16'h0000;
    else
      param_rdata <= param_mem[param_addr]; // RULE16
  end

endmodule : servo_alarm_manager

// ---- verification/servo_alarm_chk.sv ----
// Purpose: Port checker of the alarm manager
// Assumes: One clock domain
// Notes:   Blink period is too long to check here
`timescale 1ns/1ps
module servo_alarm_chk
(
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rstn,
  // Watched ports
  input wire alarm_pkg::detect_type  detect,
  input wire logic                   seq_reset,
  input wire alarm_pkg::display_type display,
  input wire alarm_pkg::stop_type    stop_action,
  input wire logic [14:0]            alarm_flags
);
  logic [3:0] top;
  // Lowest set index is the most urgent alarm
  always_comb
  begin
    top = 4'hf;
    for (int i = 14; i >= 0; i--)
      if (alarm_flags[i])
        top = 4'(i);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_clear; !seq_reset ##1 seq_reset; endsequence
  property p_oc; detect.overcurrent1 |-> ##5 alarm_flags[0]; endproperty
  property p_ov; (detect.dc_link_v > alarm_pkg::DC_LINK_LIMIT_V) |-> ##5 alarm_flags[3]; endproperty
  property p_fatal; 1 |-> (alarm_flags & $past(alarm_flags) & alarm_pkg::FATAL_MASK)
    == ($past(alarm_flags) & alarm_pkg::FATAL_MASK); endproperty
  property p_prio; (alarm_flags != 0) |=> display.alarm_shown && display.alarm_code == $past(top); endproperty
  property p_idle; (alarm_flags == 0) |=> !display.alarm_shown; endproperty
  property p_coast; ((alarm_flags & alarm_pkg::COAST_MASK) != 0) |=> stop_action == alarm_pkg::STOP_COAST; endproperty
  property p_decel; (alarm_flags != 0 && (alarm_flags & alarm_pkg::COAST_MASK) == 0)
    |=> stop_action == alarm_pkg::STOP_DECEL_COAST; endproperty
  property p_clear; s_clear |-> ##[1:5] ((alarm_flags & ~alarm_pkg::FATAL_MASK) == 0); endproperty
  a_oc: assert property (p_oc) else $error("overcurrent not latched");
  a_ov: assert property (p_ov) else $error("overvoltage not latched");
  a_fatal: assert property (p_fatal) else $error("fatal alarm dropped");
  a_prio: assert property (p_prio) else $error("wrong alarm shown");
  a_idle: assert property (p_idle) else $error("alarm shown without flag");
  a_coast: assert property (p_coast) else $error("coast stop missing");
  a_decel: assert property (p_decel) else $error("decel stop missing");
  a_clear: assert property (p_clear) else $error("clear ignored");
endmodule : servo_alarm_chk
bind servo_alarm_manager servo_alarm_chk i_servo_alarm_chk (.clk(clk), .rstn(rstn), .detect(detect),
  .seq_reset(seq_reset), .display(display), .stop_action(stop_action), .alarm_flags(alarm_flags));

// ---- verification/op_model.sv ----
// Purpose: Sequence controller and keypad driving the reset lines
// Assumes: Bench holds a request for the pulse length
// Notes:   Lines idle low so each request makes a fresh edge
`timescale 1ns/1ps
module op_model
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Bench requests
  input  wire logic want_seq,
  input  wire logic want_key,
  // Reset lines
  output logic      seq_reset,
  output logic      keypad_alarm_reset
);
  // Registered so the lines change just after an edge
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      {seq_reset, keypad_alarm_reset} <= 2'h0;
    else
      {seq_reset, keypad_alarm_reset} <= {want_seq, want_key};
endmodule : op_model

// ---- verification/tb.sv ----
// Purpose: Self-checking bench of the alarm manager
// Assumes: Blink toggle is too slow to reach
// Notes:   Flag changes are scored from a queue
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %0t %h %h", $time, g, e); end end
module tb;
  logic                        clk, rstn, want_seq, want_key, seq_reset, keypad_alarm_reset, param_wr, display_on;
  alarm_pkg::detect_type       detect;
  alarm_pkg::control_mode_type mode_in;
  alarm_pkg::seq_state_type    seq_in;
  alarm_pkg::display_type      display;
  alarm_pkg::stop_type         stop_action;
  logic [7:0]                  display_select;
  logic [24:0]                 func;
  logic [6:0]                  param_addr;
  logic [15:0]                 param_wdata, param_rdata;
  logic [14:0]                 alarm_flags, flags, prev_flags;
  logic [21:0]                 q[$];
  int                          mismatches, total_checks;
  servo_alarm_manager i_servo_alarm_manager (.clk(clk), .rstn(rstn), .detect(detect), .mode_in(mode_in),
    .seq_in(seq_in), .display_select(display_select), .sequence_input_terminal_func(func), .seq_reset(seq_reset),
    .keypad_alarm_reset(keypad_alarm_reset), .param_wr(param_wr), .param_addr(param_addr), .param_wdata(param_wdata),
    .param_rdata(param_rdata), .display(display), .display_on(display_on), .stop_action(stop_action),
    .alarm_flags(alarm_flags));
  op_model i_op_model (.clk(clk), .rstn(rstn), .want_seq(want_seq), .want_key(want_key), .seq_reset(seq_reset),
    .keypad_alarm_reset(keypad_alarm_reset));
  // Clock
  always #5 clk = ~clk;
  function automatic logic [21:0] note(logic [14:0] f);
    logic [3:0] c;
    c = 4'hf;
    for (int i = 14; i >= 0; i--)
      if (f[i])
        c = 4'(i);
    return {f, |f, c, f == 0 ? alarm_pkg::STOP_NONE : (f & alarm_pkg::COAST_MASK) != 0 ?
      alarm_pkg::STOP_COAST : alarm_pkg::STOP_DECEL_COAST};
  endfunction : note
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic fault(int i, logic on);
    case (i)
      0: detect.overcurrent1 = on;
      1: detect.overcurrent2 = on;
      2: detect.speed = on ? 16'h0100 : 16'h00ff;
      3: detect.dc_link_v = on ? 16'h01a5 : 16'h01a4;
      9: func[9:5] = on ? func[4:0] : 5'h02;
      default: detect[i < 9 ? 13 - i : 14 - i] = on;
    endcase
  endtask : fault
  // Fault pulses briefly; flags must stay latched afterwards
  task automatic raise(logic [14:0] set);
    if ((flags | set) != flags)
      q.push_back(note(flags | set));
    flags |= set;
    for (int i = 0; i < 15; i++)
      if (set[i])
        fault(i, 1);
    tick(8);
    for (int i = 0; i < 15; i++)
      fault(i, 0);
    tick(6);
    `CHK(alarm_flags, flags)
    `CHK(display.blank, 1'b0)
  endtask : raise
  task automatic clear(logic key);
    if ((flags & alarm_pkg::FATAL_MASK) != flags)
      q.push_back(note(flags & alarm_pkg::FATAL_MASK));
    flags &= alarm_pkg::FATAL_MASK;
    {want_key, want_seq} = {key, !key};
    tick(3);
    {want_key, want_seq} = 2'h0;
    tick(6);
    `CHK(alarm_flags, flags)
  endtask : clear
  task automatic power_cycle;
    rstn = 0;
    flags = 0;
    tick(4);
    rstn = 1;
    tick(2);
  endtask : power_cycle
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  // Score each flag change one edge later, once display and stop follow
  initial
  forever
  begin
    tick();
    if (!rstn)
      prev_flags = 15'h0;
    else if (alarm_flags !== prev_flags)
    begin
      prev_flags = alarm_flags;
      tick();
      `CHK({alarm_flags, display.alarm_shown, display.alarm_code, stop_action}, q.size() ? q.pop_front() : 22'h0)
    end
  end
  // Watchdog: ten thousand cycles, about sixteen times the expected run of some 620 cycles
  initial
  begin
    #100000;
    mismatches++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    {clk, rstn, want_seq, want_key, param_wr, flags, mismatches, total_checks} = '0;
    {detect, param_addr, param_wdata, mode_in, seq_in, display_select} = '0;
    detect.max_speed = 16'h00e8;
    detect.speed = 16'h00ff;
    detect.dc_link_v = 16'h01a4;
    func = {5'h05, 5'h05, 5'h03, 5'h02, 5'h01};
    void'($urandom(68604));
    power_cycle();
    `CHK({display_on, alarm_flags, stop_action}, {1'b1, 15'h0, alarm_pkg::STOP_NONE})
    for (int k = 0; k < 24; k++)
    begin
      mode_in = alarm_pkg::control_mode_type'(k % 3);
      seq_in = alarm_pkg::seq_state_type'(k / 3);
      display_select = 8'($urandom);
      tick(3);
      `CHK({display.alarm_shown, display.mode, display.seq, display.select}, {1'b0, mode_in, seq_in, display_select})
    end
    // Each alarm alone; fatal ones need a power cycle
    for (int i = 0; i < 15; i++)
    begin
      raise(15'h1 << i);
      clear(i[0]);
      if (alarm_pkg::FATAL_MASK[i])
        power_cycle();
    end
    for (int k = 0; k < 8; k++)
    begin
      raise((15'h1 << ($urandom % 15)) | (15'h1 << ($urandom % 15)));
      power_cycle();
    end
    for (int k = 0; k < 4; k++)
    begin
      param_addr = 7'($urandom);
      param_wdata = 16'($urandom);
      param_wr = 1;
      tick();
      param_wr = 0;
      tick(2);
      `CHK(param_rdata, param_wdata)
    end
    `CHK(q.size(), 0)
    wrap_up();
  end
endmodule : tb
